// [qrb_ctl_model.sv]
// controller-side model: requests and write words on the link
module qrb_ctl_model #(
   parameter int ADDR_W = 8
) (
   input wire logic i_link_clk,
   input wire qrb_pkg::qrb_echo_t i_echo,
   output logic o_read_select_n,
   output logic [ADDR_W-1:0] o_address,
   output qrb_pkg::qrb_write_port_t o_write_port
);
   typedef logic [3:0][qrb_pkg::WORD_W-1:0] qrb_words_t;
   initial begin
      o_read_select_n = 1'b1;
      o_address = '0;
      o_write_port = '1;
   end
   // waits for a K# rise so that the following K rise samples the request
   task automatic k_req(input logic rd_n, input logic wr_n,
         input logic [ADDR_W-1:0] a);
      int n;
      n = 0;
      @(posedge i_link_clk);
      while (i_echo.true_clk !== 1'b1 && n < 4) begin
         @(posedge i_link_clk);
         n++;
      end
      o_read_select_n <= rd_n;
      o_write_port.write_select_n <= wr_n;
      o_address <= a;
      @(posedge i_link_clk);
      o_read_select_n <= 1'b1;
      o_write_port.write_select_n <= 1'b1;
      o_address <= ~a;
   endtask : k_req
   // one word per edge from the edge after the request, then data inverted
   task automatic put_words(input qrb_words_t w, input logic [3:0][1:0] b);
      for (int i = 0; i < 4; i++) begin
         @(posedge i_link_clk);
         o_write_port.write_data_in <= w[i];
         o_write_port.byte_write_select_n <= b[i];
      end
      @(posedge i_link_clk);
      o_write_port.write_data_in <= ~w[3];
      o_write_port.byte_write_select_n <= b[3];
   endtask : put_words
endmodule : qrb_ctl_model

// [qrb_pkg.sv]
// shared constants and carrier types for the burst sram port logic
package qrb_pkg;

   // ------------------------------------------------------------------
   // geometry
   // ------------------------------------------------------------------
   localparam int WORD_W = 18;
   localparam int BYTE_W = 9;
   localparam int ADDR_W = 19;
   localparam logic [2:0] BURST_LAST = 3'h3;
   localparam logic [1:0] IDX_FIRST = 2'h0;
   localparam logic [1:0] IDX_SECOND = 2'h1;

   // ------------------------------------------------------------------
   // timing on the system clock
   // ------------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 25000;
   localparam int LOCK_TIME_US = 20;
   localparam int LOCK_CYCLES =
      (LOCK_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int STOP_TIME_NS = 30;
   localparam int STOP_CYCLES =
      (STOP_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

   // ------------------------------------------------------------------
   // timing on the link, in link edges (one per K or K# rise); impedance interval in K cycles
   // ------------------------------------------------------------------
   localparam int LAT_PLL_EDGES = 5;
   localparam int LAT_BYPASS_EDGES = 2;
   localparam int WR_DELAY_EDGES = 2;
   localparam int IMPEDANCE_CYCLES = 1024;
   localparam int IMP_CNT_W = $clog2(IMPEDANCE_CYCLES);
   localparam logic [IMP_CNT_W-1:0] IMP_LAST =
      IMP_CNT_W'(IMPEDANCE_CYCLES - 1);

   // ------------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------------
   localparam logic RST_KPHASE = 1'b1;
   localparam logic RST_OE_N = 1'b1;
   localparam logic RST_TERM_HIGH = 1'b1;

   // ------------------------------------------------------------------
   // carriers and states
   // ------------------------------------------------------------------
   typedef struct packed {
      logic write_select_n;
      logic [1:0] byte_write_select_n;
      logic [WORD_W-1:0] write_data_in;
   } qrb_write_port_t;

   typedef struct packed {
      logic [WORD_W-1:0] read_data_out;
      logic read_data_oe_n;
      logic read_valid;
   } qrb_read_port_t;

   typedef struct packed {
      logic true_clk;
      logic comp_clk;
   } qrb_echo_t;

   typedef enum logic [1:0] {
      QRB_IDLE,
      QRB_READ,
      QRB_WRITE
   } qrb_last_op_t;

endpackage : qrb_pkg

// [qrb_ports_chk_sva.sv]
// pin-level checker for the burst sram port logic
module qrb_ports_chk (
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_link_clk,
   input wire logic i_pll_disable_n,
   input wire logic i_termination_range_select,
   input wire logic i_read_select_n,
   input wire qrb_pkg::qrb_read_port_t o_read_port,
   input wire qrb_pkg::qrb_echo_t o_echo_clock,
   input wire logic o_impedance_update,
   input wire logic o_termination_high_range
);
   // ----------------------------------------
   // helper state on the link clock
   // ----------------------------------------
   logic k_edge;
   logic rd_go;
   logic last_rd;
   logic seen;
   logic [11:0] imp_cnt;
   // echo level still shows the previous edge: low means this is a K rise
   assign k_edge = !o_echo_clock.true_clk;
   assign rd_go = k_edge && !i_read_select_n && !last_rd;
   always_ff @(posedge i_link_clk) begin
      if (i_reset) begin
         last_rd <= 1'b0;
      end else if (k_edge) begin
         last_rd <= rd_go;
      end
   end
   always_ff @(posedge i_link_clk) begin
      if (i_reset) begin
         imp_cnt <= 12'h000;
         seen <= 1'b0;
      end else if (o_impedance_update) begin
         imp_cnt <= 12'h000;
         seen <= 1'b1;
      end else begin
         imp_cnt <= imp_cnt + 12'h001;
      end
   end
   sequence s_words;
      !o_read_port.read_data_oe_n [*4];
   endsequence
   // a read with no read starting at the next two K rises
   sequence s_lone_rd;
      (rd_go && i_pll_disable_n) ##2 !rd_go ##2 !rd_go;
   endsequence
   chk_rd_pll_lat: assert property (@(posedge i_link_clk)
      disable iff (i_reset) rd_go && i_pll_disable_n
      |-> ##5 o_read_port.read_valid ##1 s_words)
      else $error("read burst timing wrong with pll on");
   chk_rd_bypass_lat: assert property (@(posedge i_link_clk)
      disable iff (i_reset) rd_go && !i_pll_disable_n
      |-> ##2 o_read_port.read_valid ##1 s_words)
      else $error("read burst timing wrong with pll off");
   chk_rd_tristate: assert property (@(posedge i_link_clk)
      disable iff (i_reset) s_lone_rd |-> ##6 o_read_port.read_data_oe_n)
      else $error("read port not released after burst");
   chk_valid_lead: assert property (@(posedge i_link_clk)
      disable iff (i_reset) $fell(o_read_port.read_data_oe_n)
      |-> $past(o_read_port.read_valid))
      else $error("valid did not lead first word");
   chk_imp_period: assert property (@(posedge i_link_clk)
      disable iff (i_reset) o_impedance_update && seen |-> imp_cnt == 12'h7FF)
      else $error("impedance update interval wrong");
   chk_imp_pulse: assert property (@(posedge i_link_clk)
      disable iff (i_reset) o_impedance_update |=> !o_impedance_update)
      else $error("impedance update longer than one edge");
   chk_echo_pair: assert property (@(posedge i_link_clk)
      disable iff (i_reset) !$past(i_reset, 4)
      |-> o_echo_clock.comp_clk != o_echo_clock.true_clk
      && o_echo_clock.true_clk != $past(o_echo_clock.true_clk))
      else $error("echo clocks not complementary and running");
   chk_term_capture: assert property (@(posedge i_clk)
      disable iff (i_reset) $fell(i_reset)
      |=> o_termination_high_range == i_termination_range_select)
      else $error("termination range not taken at release");
   chk_term_hold: assert property (@(posedge i_clk)
      disable iff (i_reset) $changed(o_termination_high_range)
      |-> $past(i_reset, 2))
      else $error("termination range changed in operation");
endmodule : qrb_ports_chk

// [qrb_sram_ports.sv]
// burst sram port logic: link-side read/write engines, pll and pin state
// How it works
// RULE1: four sequential words per access, one address
// RULE2: read select low at K captures address
// RULE3: read words follow after latency, one per edge
// RULE4: back-to-back read request is ignored
// RULE5: reads every other K stream gaplessly
// RULE6: deselected read port tri-states after K# rise
// RULE7: write select low at K, data next K
// RULE8: four write words captured then stored
// RULE9: back-to-back write request is ignored
// RULE10: deselected write port finishes, then ignores inputs
// RULE11: byte selects sampled per word, active low
// RULE12: first select low byte, second upper byte
// RULE13: read and write engines run independently
// RULE14: read after write returns newest data
// RULE15: controller starts one transaction per cycle
// RULE16: both selected: read unless last was read
// RULE17: both held from idle alternates, read first
// RULE18: selects sampled only on K rises
// RULE19: impedance update every 1024 K cycles
// RULE20: free-running echo clocks follow K and K#
// RULE21: read valid leads first word by half cycle
// RULE22: termination range caught at power-up
// RULE23: pll locks 20 us after stable clock
// RULE24: clock stopped 30 ns resets pll lock
// RULE25: pll disable low turns pll off
// RULE26: latency 2.5 cycles with pll, else 1
// RULE27: powers up deselected with outputs tri-stated
// RULE28: burst walks latched address plus three steps
// RULE29: controller waits for lock before accesses
module qrb_sram_ports #(
   parameter int ADDR_W = qrb_pkg::ADDR_W,
   parameter int LOCK_CYCLES = qrb_pkg::LOCK_CYCLES,
   parameter int STOP_CYCLES = qrb_pkg::STOP_CYCLES
) (
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_link_clk,
   input wire logic i_pll_disable_n,
   input wire logic i_termination_range_select,
   input wire logic i_read_select_n,
   input wire logic [ADDR_W-1:0] i_address,
   input wire qrb_pkg::qrb_write_port_t i_write_port,
   output qrb_pkg::qrb_read_port_t o_read_port,
   output qrb_pkg::qrb_echo_t o_echo_clock,
   output logic o_impedance_update,
   output logic o_pll_locked,
   output logic o_termination_high_range
);

   // ------------------------------------------------------------------
   // elaboration checks
   // ------------------------------------------------------------------
   if (ADDR_W < 1 || ADDR_W > qrb_pkg::ADDR_W) begin : g_bad_addr
      $error("qrb_sram_ports: ADDR_W out of range");
   end
   if (LOCK_CYCLES < 1 || STOP_CYCLES < 1) begin : g_bad_counts
      $error("qrb_sram_ports: LOCK_CYCLES and STOP_CYCLES must be >= 1");
   end

   localparam int RD_DEPTH = qrb_pkg::LAT_PLL_EDGES;
   localparam int WR_DEPTH = qrb_pkg::WR_DELAY_EDGES;
   localparam int LOCK_W = $clog2(LOCK_CYCLES + 1);
   localparam int STOP_W = $clog2(STOP_CYCLES + 1);
   localparam logic [LOCK_W-1:0] LOCK_DONE = LOCK_W'(LOCK_CYCLES);
   localparam logic [STOP_W-1:0] STOP_DONE = STOP_W'(STOP_CYCLES);
   localparam int MEM_WORDS = 2 ** (ADDR_W + 2);

   // burst word k of location a lives in mem at index {a, k}
   function automatic logic [ADDR_W+1:0] word_index(
      input logic [ADDR_W-1:0] addr,
      input logic [1:0] idx
   );
      word_index = {addr, idx};
   endfunction : word_index

   // ------------------------------------------------------------------
   // crossings into the link domain
   // ------------------------------------------------------------------
   logic link_reset;
   logic link_pll_on;

   qrb_sync #(
      .WIDTH(2)
   ) u_link_sync (
      .i_clk(i_link_clk),
      .i_async({i_reset, i_pll_disable_n}),
      .o_sync({link_reset, link_pll_on})
   );

   // ------------------------------------------------------------------
   // link phase and echo clocks
   // ------------------------------------------------------------------
   // every link edge is one K or K# rise; kphase marks the K rises
   logic kphase;
   logic link_toggle;

   always_ff @(posedge i_link_clk) begin
      if (link_reset) begin
         kphase <= qrb_pkg::RST_KPHASE;
      end else begin
         kphase <= ~kphase;
      end
   end

   // echo flops carry no reset; they stall only while the phase is reset
   always_ff @(posedge i_link_clk) begin
      o_echo_clock.true_clk <= kphase; // RULE20
      o_echo_clock.comp_clk <= ~kphase; // RULE20
   end

   // activity marker read by the pll model on the system clock
   always_ff @(posedge i_link_clk) begin
      if (link_reset) begin
         link_toggle <= 1'b0;
      end else begin
         link_toggle <= ~link_toggle;
      end
   end

   // ------------------------------------------------------------------
   // arbitration
   // ------------------------------------------------------------------
   qrb_pkg::qrb_last_op_t last_op;
   logic start_read;
   logic start_write;

   always_comb begin
      start_read = 1'b0;
      start_write = 1'b0;
      if (kphase && !link_reset) begin // RULE18
         // a read right after a read is dropped, a write steps in
         start_read = !i_read_select_n
            && (last_op != qrb_pkg::QRB_READ); // RULE4 RULE16 RULE17
         start_write = !i_write_port.write_select_n
            && (last_op != qrb_pkg::QRB_WRITE)
            && !start_read; // RULE9 RULE16 RULE17
      end
   end

   always_ff @(posedge i_link_clk) begin
      if (link_reset) begin
         last_op <= qrb_pkg::QRB_IDLE; // RULE27
      end else if (kphase) begin
         if (start_read) begin
            last_op <= qrb_pkg::QRB_READ;
         end else if (start_write) begin
            last_op <= qrb_pkg::QRB_WRITE;
         end else begin
            last_op <= qrb_pkg::QRB_IDLE;
         end
      end
   end

   // ------------------------------------------------------------------
   // storage
   // ------------------------------------------------------------------
   logic [qrb_pkg::WORD_W-1:0] mem [MEM_WORDS]; // RULE1

   // ------------------------------------------------------------------
   // read request pipeline
   // ------------------------------------------------------------------
   logic [RD_DEPTH-1:0] rd_pend;
   logic [ADDR_W-1:0] rd_pend_addr [RD_DEPTH];
   logic rd_tap_now;
   logic rd_tap_soon;
   logic [ADDR_W-1:0] rd_tap_addr;

   always_ff @(posedge i_link_clk) begin
      if (link_reset) begin
         rd_pend <= '0;
      end else begin
         rd_pend <= {rd_pend[RD_DEPTH-2:0], start_read};
      end
   end

   // address latched at the request, then carried with it
   always_ff @(posedge i_link_clk) begin
      rd_pend_addr[0] <= i_address; // RULE2
      for (int i = 1; i < RD_DEPTH; i++) begin
         rd_pend_addr[i] <= rd_pend_addr[i-1];
      end
   end

   // the tap sets latency: five edges with the pll, two without
   always_comb begin
      if (link_pll_on) begin // RULE25 RULE26
         rd_tap_now = rd_pend[qrb_pkg::LAT_PLL_EDGES-1];
         rd_tap_soon = rd_pend[qrb_pkg::LAT_PLL_EDGES-2];
         rd_tap_addr = rd_pend_addr[qrb_pkg::LAT_PLL_EDGES-1];
      end else begin
         rd_tap_now = rd_pend[qrb_pkg::LAT_BYPASS_EDGES-1];
         rd_tap_soon = rd_pend[qrb_pkg::LAT_BYPASS_EDGES-2];
         rd_tap_addr = rd_pend_addr[qrb_pkg::LAT_BYPASS_EDGES-1];
      end
   end

   // ------------------------------------------------------------------
   // read burst engine
   // ------------------------------------------------------------------
   logic [2:0] rd_left;
   logic [1:0] rd_idx;
   logic [ADDR_W-1:0] rd_addr;
   logic rd_more;

   always_ff @(posedge i_link_clk) begin
      if (link_reset) begin
         rd_left <= 3'h0;
         rd_idx <= 2'h0;
         rd_addr <= '0;
      end else if (rd_tap_now) begin // RULE3
         rd_addr <= rd_tap_addr;
         rd_idx <= qrb_pkg::IDX_SECOND;
         rd_left <= qrb_pkg::BURST_LAST;
      end else if (rd_left != 3'h0) begin
         rd_idx <= rd_idx + 2'h1; // RULE28
         rd_left <= rd_left - 3'h1;
      end
   end

   // a word is due on the next edge: new burst or more of this one
   assign rd_more = rd_tap_soon || rd_tap_now || (rd_left > 3'h1);

   // memory is read at output time, so words written earlier in a
   // neighbouring burst are always seen without a bypass path
   always_ff @(posedge i_link_clk) begin
      if (link_reset) begin
         o_read_port.read_data_out <= '0;
         o_read_port.read_data_oe_n <= qrb_pkg::RST_OE_N; // RULE27
         o_read_port.read_valid <= 1'b0;
      end else begin
         o_read_port.read_valid <= rd_more; // RULE21
         if (rd_tap_now) begin
            o_read_port.read_data_out <=
               mem[word_index(rd_tap_addr, qrb_pkg::IDX_FIRST)]; // RULE14
            o_read_port.read_data_oe_n <= 1'b0;
         end else if (rd_left != 3'h0) begin // RULE5
            o_read_port.read_data_out <=
               mem[word_index(rd_addr, rd_idx)]; // RULE28
            o_read_port.read_data_oe_n <= 1'b0;
         end else if (!kphase) begin
            // release only on a K# rise so a neighbour can take over
            o_read_port.read_data_oe_n <= 1'b1; // RULE6
         end
      end
   end

   // ------------------------------------------------------------------
   // write request pipeline
   // ------------------------------------------------------------------
   logic [WR_DEPTH-1:0] wr_pend;
   logic [ADDR_W-1:0] wr_pend_addr [WR_DEPTH];
   logic wr_tap;

   always_ff @(posedge i_link_clk) begin
      if (link_reset) begin
         wr_pend <= '0;
      end else begin
         wr_pend <= {wr_pend[WR_DEPTH-2:0], start_write}; // RULE7
      end
   end

   always_ff @(posedge i_link_clk) begin
      wr_pend_addr[0] <= i_address; // RULE13
      for (int i = 1; i < WR_DEPTH; i++) begin
         wr_pend_addr[i] <= wr_pend_addr[i-1];
      end
   end

   assign wr_tap = wr_pend[WR_DEPTH-1];

   // ------------------------------------------------------------------
   // write burst engine
   // ------------------------------------------------------------------
   logic [2:0] wr_left;
   logic [1:0] wr_idx;
   logic [ADDR_W-1:0] wr_addr;
   logic wr_capture;
   logic [ADDR_W+1:0] wr_word;

   always_ff @(posedge i_link_clk) begin
      if (link_reset) begin
         wr_left <= 3'h0;
         wr_idx <= 2'h0;
         wr_addr <= '0;
      end else if (wr_tap) begin // RULE8
         wr_addr <= wr_pend_addr[WR_DEPTH-1];
         wr_idx <= qrb_pkg::IDX_SECOND;
         wr_left <= qrb_pkg::BURST_LAST;
      end else if (wr_left != 3'h0) begin
         wr_idx <= wr_idx + 2'h1;
         wr_left <= wr_left - 3'h1;
      end
   end

   // outside a burst nothing on the write data and byte select pins is looked at
   assign wr_capture = wr_tap || (wr_left != 3'h0); // RULE10

   always_comb begin
      if (wr_tap) begin
         wr_word = word_index(wr_pend_addr[WR_DEPTH-1], qrb_pkg::IDX_FIRST);
      end else begin
         wr_word = word_index(wr_addr, wr_idx); // RULE28
      end
   end

   // each word lands as it arrives; that gives the same stored result
   // as holding all four, and keeps later reads coherent
   always_ff @(posedge i_link_clk) begin
      if (wr_capture) begin // RULE8
         if (!i_write_port.byte_write_select_n[0]) begin // RULE11
            mem[wr_word][qrb_pkg::BYTE_W-1:0] <=
               i_write_port.write_data_in[qrb_pkg::BYTE_W-1:0]; // RULE12
         end
         if (!i_write_port.byte_write_select_n[1]) begin // RULE11
            mem[wr_word][qrb_pkg::WORD_W-1:qrb_pkg::BYTE_W] <=
               i_write_port.write_data_in[qrb_pkg::WORD_W-1:qrb_pkg::BYTE_W];
         end
      end
   end

   // ------------------------------------------------------------------
   // impedance update
   // ------------------------------------------------------------------
   logic [qrb_pkg::IMP_CNT_W-1:0] imp_cnt;

   always_ff @(posedge i_link_clk) begin
      if (link_reset) begin
         imp_cnt <= '0;
         o_impedance_update <= 1'b0;
      end else begin
         o_impedance_update <= 1'b0;
         if (kphase) begin
            if (imp_cnt == qrb_pkg::IMP_LAST) begin
               imp_cnt <= '0;
               o_impedance_update <= 1'b1; // RULE19
            end else begin
               imp_cnt <= imp_cnt + 1'b1;
            end
         end
      end
   end

   // ------------------------------------------------------------------
   // system clock side: pins and link activity
   // ------------------------------------------------------------------
   logic pll_on;
   logic term_sel;
   logic toggle_sync;
   logic toggle_seen;
   logic init_done;

   qrb_sync #(
      .WIDTH(3)
   ) u_clk_sync (
      .i_clk(i_clk),
      .i_async({i_pll_disable_n, i_termination_range_select, link_toggle}),
      .o_sync({pll_on, term_sel, toggle_sync})
   );

   // termination range is caught once, on the first cycle after reset
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         init_done <= 1'b0;
         o_termination_high_range <= qrb_pkg::RST_TERM_HIGH;
      end else if (!init_done) begin
         init_done <= 1'b1;
         o_termination_high_range <= term_sel; // RULE22
      end
   end

   // ------------------------------------------------------------------
   // pll lock model
   // ------------------------------------------------------------------
   // the rate cannot be measured at this clock, so any steady toggling
   // counts as a stable clock; only a stop, reset or pll disable restarts the lock
   logic [STOP_W-1:0] stop_cnt;
   logic [LOCK_W-1:0] lock_cnt;
   logic clk_stopped;

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         toggle_seen <= 1'b0;
      end else begin
         toggle_seen <= toggle_sync;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_reset || (toggle_seen != toggle_sync)) begin
         stop_cnt <= '0;
      end else if (stop_cnt != STOP_DONE) begin
         stop_cnt <= stop_cnt + 1'b1;
      end
   end

   assign clk_stopped = (stop_cnt == STOP_DONE); // RULE24

   always_ff @(posedge i_clk) begin
      if (i_reset || !pll_on || clk_stopped) begin // RULE24 RULE25
         lock_cnt <= '0;
         o_pll_locked <= 1'b0;
      end else if (lock_cnt == LOCK_DONE) begin
         o_pll_locked <= 1'b1; // RULE23
      end else begin
         lock_cnt <= lock_cnt + 1'b1;
      end
   end

endmodule : qrb_sram_ports

// [qrb_sync.sv]
// two-flop level synchroniser, one chain per bit
module qrb_sync #(
   parameter int WIDTH = 1
) (
   input wire logic i_clk,
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);

   logic [WIDTH-1:0] meta;

   if (WIDTH < 1) begin : g_bad_width
      $error("qrb_sync: WIDTH must be at least 1");
   end

   // the first stage feeds only the second stage
   always_ff @(posedge i_clk) begin
      meta <= i_async;
      o_sync <= meta;
   end

endmodule : qrb_sync

// [tb_top.sv]
// top bench: clocks, reset, scenarios and verdict for the port logic
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int AW = 8;
   typedef logic [3:0][qrb_pkg::WORD_W-1:0] qrb_burst_t;
   logic i_clk = 1'b0;
   logic lclk = 1'b0;
   logic lk_run = 1'b1;
   logic i_reset = 1'b1;
   logic pll_n = 1'b1;
   logic term_sel = 1'b0;
   logic rd_n;
   logic [AW-1:0] addr;
   qrb_pkg::qrb_write_port_t wport;
   qrb_pkg::qrb_read_port_t rport;
   qrb_pkg::qrb_echo_t echo;
   logic imp_upd;
   logic locked;
   logic term_hi;
   int err_count = 0;
   int total_checks = 0;
   int clk_cnt = 0;
   int n;
   qrb_burst_t q;
   qrb_burst_t d0;
   qrb_burst_t d1;
   qrb_burst_t e;
   always #12.5 i_clk = ~i_clk;
   always #32 if (lk_run) lclk = ~lclk;
   always @(posedge i_clk) clk_cnt <= clk_cnt + 1;
   qrb_sram_ports #(.ADDR_W(AW), .LOCK_CYCLES(20), .STOP_CYCLES(5)) dut (
      .i_clk(i_clk), .i_reset(i_reset), .i_link_clk(lclk),
      .i_pll_disable_n(pll_n), .i_termination_range_select(term_sel),
      .i_read_select_n(rd_n), .i_address(addr), .i_write_port(wport),
      .o_read_port(rport), .o_echo_clock(echo), .o_impedance_update(imp_upd),
      .o_pll_locked(locked), .o_termination_high_range(term_hi));
   qrb_ctl_model #(.ADDR_W(AW)) ctl (.i_link_clk(lclk), .i_echo(echo),
      .o_read_select_n(rd_n), .o_address(addr), .o_write_port(wport));
   // ----------------------------------------
   // checking and access tasks
   // ----------------------------------------
   task automatic chk(input string what, input logic [17:0] x,
         input logic [17:0] g);
      total_checks++;
      if (g !== x) begin
         $display("[ERR] %s expected %h seen %h", what, x, g);
         err_count++;
      end
   endtask : chk
   task automatic conclude();
      if (err_count == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : conclude
   task automatic get_words(input int lat, output qrb_burst_t r);
      repeat (lat) @(posedge lclk);
      for (int i = 0; i < 4; i++) begin
         #1;
         r[i] = rport.read_data_out;
         chk("read enable", 18'h0, {17'h0, rport.read_data_oe_n});
         if (i < 3) @(posedge lclk);
      end
   endtask : get_words
   task automatic rd_burst(input logic [AW-1:0] a, input int lat);
      ctl.k_req(1'b0, 1'b1, a);
      get_words(lat, q);
   endtask : rd_burst
   // read issued at the K rise right after the write starts
   task automatic wr_rd(input logic [AW-1:0] a, input qrb_burst_t w,
         input logic [7:0] b, input int lat);
      ctl.k_req(1'b1, 1'b0, a);
      fork
         ctl.put_words(w, b);
         rd_burst(a, lat);
      join
   endtask : wr_rd
   task automatic cmp(input string what, input qrb_burst_t x);
      for (int i = 0; i < 4; i++) chk(what, x[i], q[i]);
   endtask : cmp
   task automatic wait_lock(input logic lvl);
      int k;
      k = 0;
      while (locked !== lvl) begin
         @(posedge i_clk);
         k++;
         if (k > 2000) begin
            $display("[ERR] lock expected %b seen %b", lvl, locked);
            err_count++;
            conclude();
         end
      end
   endtask : wait_lock
   task automatic wait_imp(output int m);
      m = 0;
      do begin
         @(posedge lclk);
         m++;
      end while (imp_upd !== 1'b1 && m < 4200);
      if (m >= 4200) begin
         $display("[ERR] impedance pulse expected 1 seen %b", imp_upd);
         err_count++;
         conclude();
      end
   endtask : wait_imp
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial begin
      d0 = {18'h3A5C1, 18'h2B4D2, 18'h1C3E3, 18'h0D2F4};
      d1 = ~d0;
      e = {d0[3], d0[2][17:9], d1[2][8:0], d1[1][17:9], d0[1][8:0], d1[0]};
      repeat (12) @(posedge i_clk);
      i_reset <= 1'b0;
      n = clk_cnt;
      repeat (8) @(posedge lclk);
      chk("term range", 18'h0, {17'h0, term_hi});
      chk("idle enable", 18'h1, {17'h0, rport.read_data_oe_n});
      chk("idle valid", 18'h0, {17'h0, rport.read_valid});
      term_sel <= 1'b1;
      wait_lock(1'b1);
      chk("lock delay", 18'h1, {17'h0, clk_cnt - n >= 20});
      wr_rd(8'h10, d0, 8'h00, 5);
      cmp("burst", d0);
      wr_rd(8'h10, d1, 8'hE4, 5);
      cmp("masked", e);
      ctl.k_req(1'b1, 1'b0, 8'h20);
      fork
         ctl.put_words(d0, 8'h00);
         ctl.k_req(1'b1, 1'b0, 8'h10);
      join
      ctl.k_req(1'b0, 1'b1, 8'h10);
      fork
         get_words(5, q);
         ctl.k_req(1'b0, 1'b1, 8'h20);
      join
      cmp("second write", e);
      @(posedge lclk);
      #1;
      chk("released", 18'h1, {17'h0, rport.read_data_oe_n});
      ctl.k_req(1'b0, 1'b0, 8'h20);
      fork
         get_words(5, q);
         begin
            ctl.k_req(1'b0, 1'b0, 8'h30);
            ctl.put_words(d1, 8'h00);
         end
      join
      cmp("both read", d0);
      ctl.k_req(1'b0, 1'b1, 8'h30);
      ctl.k_req(1'b1, 1'b1, 8'h00);
      ctl.k_req(1'b0, 1'b1, 8'h20);
      get_words(1, q);
      cmp("both write", d1);
      get_words(1, q);
      cmp("gapless", d0);
      wait_imp(n);
      wait_imp(n);
      chk("impedance interval", 18'h800, n[17:0]);
      lk_run = 1'b0;
      wait_lock(1'b0);
      lk_run = 1'b1;
      n = clk_cnt;
      wait_lock(1'b1);
      chk("relock delay", 18'h1, {17'h0, clk_cnt - n >= 20});
      @(posedge i_clk);
      i_reset <= 1'b1;
      pll_n <= 1'b0;
      repeat (12) @(posedge i_clk);
      i_reset <= 1'b0;
      repeat (8) @(posedge lclk);
      chk("term range", 18'h1, {17'h0, term_hi});
      wr_rd(8'h40, d0, 8'h00, 2);
      cmp("bypass", d0);
      conclude();
   end
endmodule : tb_top

bind qrb_sram_ports qrb_ports_chk chk_i (
   .i_clk(i_clk), .i_reset(i_reset), .i_link_clk(i_link_clk),
   .i_pll_disable_n(i_pll_disable_n),
   .i_termination_range_select(i_termination_range_select),
   .i_read_select_n(i_read_select_n), .o_read_port(o_read_port),
   .o_echo_clock(o_echo_clock), .o_impedance_update(o_impedance_update),
   .o_termination_high_range(o_termination_high_range));
